// ===== tcpp_pkg.sv
// Purpose: constants and types for the two-channel timer pwm block
// Assumes: axi4-lite register access, 32-bit data
// Notes:   register offsets are byte addresses
package tcpp_pkg;
    localparam logic [7:0]  ADDR_CLOCK_GATE   = 8'h00;
    localparam logic [7:0]  ADDR_PRESCALER    = 8'h04;
    localparam logic [7:0]  ADDR_MASTER_MODE  = 8'h08;
    localparam logic [7:0]  ADDR_MASTER_PER   = 8'h0C;
    localparam logic [7:0]  ADDR_SLAVE_MODE   = 8'h10;
    localparam logic [7:0]  ADDR_SLAVE_DUTY   = 8'h14;
    localparam logic [7:0]  ADDR_OUT_CTRL     = 8'h18;
    localparam logic [7:0]  ADDR_START        = 8'h1C;
    localparam logic [7:0]  ADDR_STATUS       = 8'h20;
    localparam logic [7:0]  ADDR_COUNT0       = 8'h24;
    localparam logic [7:0]  ADDR_COUNT1       = 8'h28;
    localparam int          GATE_BIT          = 0;
    localparam int          CKS_HI            = 15;
    localparam int          CKS_LO            = 14;
    localparam int          CCS_BIT           = 12;
    localparam int          MS_BIT            = 11;
    localparam int          STS_HI            = 10;
    localparam int          STS_LO            = 8;
    localparam int          CIS_HI            = 7;
    localparam int          CIS_LO            = 6;
    localparam int          MD_HI             = 3;
    localparam int          MD_LO             = 1;
    localparam int          MD0_BIT           = 0;
    localparam int          OM_BIT            = 0;
    localparam int          OE_BIT            = 1;
    localparam int          OUTV_BIT          = 2;
    localparam logic [15:0] MODE_RESET        = 16'h0000;
    localparam logic [15:0] DATA_RESET        = 16'h0000;
    localparam logic [3:0]  PRS_RESET         = 4'h0;
    localparam logic [2:0]  MD_INTERVAL       = 3'h0;
    localparam logic [2:0]  MD_CAPTURE        = 3'h2;
    localparam logic [2:0]  MD_EVENT          = 3'h3;
    localparam logic [2:0]  MD_ONECOUNT       = 3'h4;
    localparam logic [2:0]  MD_CAP_ONE        = 3'h6;
    localparam logic [2:0]  STS_SOFT          = 3'h0;
    localparam logic [2:0]  STS_EDGE          = 3'h1;
    localparam logic [2:0]  STS_BOTH          = 3'h2;
    localparam logic [2:0]  STS_MASTER        = 3'h4;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    typedef struct packed {
        logic [1:0] operating_clock_select;
        logic       count_clock_source;
        logic       split_or_master;
        logic [2:0] trigger_source_field;
        logic [1:0] input_edge_field;
        logic [2:0] operating_mode_field;
        logic       start_behaviour_bit;
    } tcpp_mode_type;

    function automatic tcpp_mode_type tcpp_unpack(input logic [15:0] r);
        tcpp_mode_type m;
        m.operating_clock_select = r[CKS_HI:CKS_LO];
        m.count_clock_source     = r[CCS_BIT];
        m.split_or_master        = r[MS_BIT];
        m.trigger_source_field   = r[STS_HI:STS_LO];
        m.input_edge_field       = r[CIS_HI:CIS_LO];
        m.operating_mode_field   = r[MD_HI:MD_LO];
        m.start_behaviour_bit    = r[MD0_BIT];
        return m;
    endfunction : tcpp_unpack
endpackage : tcpp_pkg

// ===== tcpp_timer.sv
// Purpose: timer unit with master/slave channel pair making pwm
// Assumes: inputs synchronous to clk; software keeps its setup order
// Notes:   register access over axi4-lite, one word per register
// How it works
// - clock gate bit 0 stops the prescaler and count clocks; 1 lets them run
// - four-bit (first, second) and two-bit (third, fourth) prescale fields divide clk by two to the field power
// - mode bits 15:14 pick prescaled clock first, third, second, fourth
// - bit 12 picks operating clock or input pin valid edges for counting
// - channel 0 bit 11 makes it group master, else independent
// - channel 1 bit 11 picks 16-bit (0) or 8-bit (1) counting
// - trigger field: software, pin edge, both edges, master interrupt
// - edge field: falling, rising, or both with start/capture edge order
// - mode bits 3:1 pick interval, capture, event, one-count, capture one-count
// - interval/capture with bit 0 set interrupt and toggle at count start
// - one-count with bit 0 set restarts on retrigger with interrupt
// - event and capture one-count: no start interrupt, retrigger ignored
// - master period equals data value plus one count clocks
// - slave output set by master interrupt, cleared by slave interrupt
// - duty equals slave data over master data plus one
// - writing 1 to start bit sets operation flag; 0 does nothing
// - output enable 1 gives timer output; 0 shows software level
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module tcpp_timer
    import tcpp_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        channel_zero_input_pin,
    input  wire logic        channel_one_input_pin,
    output logic             pwm_output_pin,
    output logic             master_expiry_interrupt,
    output logic             slave_expiry_interrupt
);
    if (WIDTH != 16) begin : g_chk
        $error("tcpp_timer: only WIDTH 16 is supported");
    end

    logic        timer_unit_clock_gate;
    logic [15:0] prescaler_reg;
    logic [15:0] master_mode;
    logic [15:0] master_period;
    logic [15:0] slave_mode;
    logic [15:0] slave_duty_value;
    logic [2:0]  out_ctrl;
    logic [1:0]  channel_operation_flag;
    logic [15:0] count0;
    logic [15:0] count1;
    logic [14:0] divider;
    logic [14:0] divider_prev;
    logic        pin0_prev;
    logic        pin1_prev;
    logic        timer_out;

    // write path: address and data latch independently, either order
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wr_lo    = w_strb[0];
    wire wr_hi    = w_strb[1];
    wire [7:0] wa = aw_addr;
    wire wa_known = wa == ADDR_CLOCK_GATE || wa == ADDR_PRESCALER || wa == ADDR_MASTER_MODE
                 || wa == ADDR_MASTER_PER || wa == ADDR_SLAVE_MODE || wa == ADDR_SLAVE_DUTY
                 || wa == ADDR_OUT_CTRL || wa == ADDR_START;
    wire start_wr = do_write && wa == ADDR_START && wr_lo;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wa_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register storage, all clear at reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_unit_clock_gate <= 1'b0;
            prescaler_reg         <= DATA_RESET;
            master_mode           <= MODE_RESET;
            master_period         <= DATA_RESET;
            slave_mode            <= MODE_RESET;
            slave_duty_value      <= DATA_RESET;
            out_ctrl              <= 3'h0;
        end else if (do_write) begin
            if (wa == ADDR_CLOCK_GATE && wr_lo) timer_unit_clock_gate <= w_data[GATE_BIT];
            if (wa == ADDR_PRESCALER && wr_lo) prescaler_reg[7:0] <= w_data[7:0];
            if (wa == ADDR_PRESCALER && wr_hi) prescaler_reg[15:8] <= w_data[15:8];
            if (wa == ADDR_MASTER_MODE && wr_lo) master_mode[7:0] <= w_data[7:0];
            if (wa == ADDR_MASTER_MODE && wr_hi) master_mode[15:8] <= w_data[15:8];
            if (wa == ADDR_MASTER_PER && wr_lo) master_period[7:0] <= w_data[7:0];
            if (wa == ADDR_MASTER_PER && wr_hi) master_period[15:8] <= w_data[15:8];
            if (wa == ADDR_SLAVE_MODE && wr_lo) slave_mode[7:0] <= w_data[7:0];
            if (wa == ADDR_SLAVE_MODE && wr_hi) slave_mode[15:8] <= w_data[15:8];
            if (wa == ADDR_SLAVE_DUTY && wr_lo) slave_duty_value[7:0] <= w_data[7:0];
            if (wa == ADDR_SLAVE_DUTY && wr_hi) slave_duty_value[15:8] <= w_data[15:8];
            if (wa == ADDR_OUT_CTRL && wr_lo) out_ctrl[1:0] <= w_data[1:0];
            // software level write ignored while timer owns the pin
            if (wa == ADDR_OUT_CTRL && wr_lo && !out_ctrl[OE_BIT]) out_ctrl[OUTV_BIT] <= w_data[OUTV_BIT];
        end
    end

    // read path
    logic [31:0] rd_mux;
    wire [7:0] ra = s_axi_araddr;
    assign s_axi_arready = !s_axi_rvalid;
    always_comb begin
        case (ra)
            ADDR_CLOCK_GATE:  rd_mux = {31'h0, timer_unit_clock_gate};
            ADDR_PRESCALER:   rd_mux = {16'h0, prescaler_reg};
            ADDR_MASTER_MODE: rd_mux = {16'h0, master_mode};
            ADDR_MASTER_PER:  rd_mux = {16'h0, master_period};
            ADDR_SLAVE_MODE:  rd_mux = {16'h0, slave_mode};
            ADDR_SLAVE_DUTY:  rd_mux = {16'h0, slave_duty_value};
            ADDR_OUT_CTRL:    rd_mux = {29'h0, out_ctrl};
            ADDR_START:       rd_mux = 32'h0000_0000;
            ADDR_STATUS:      rd_mux = {29'h0, pwm_output_pin, channel_operation_flag};
            ADDR_COUNT0:      rd_mux = {16'h0, count0};
            ADDR_COUNT1:      rd_mux = {16'h0, count1};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end
    wire ra_known = ra <= ADDR_COUNT1 && ra[1:0] == 2'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= ra_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // prescaler: a bit falling in the free divider marks one period of clk/2^n
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divider      <= 15'h0000;
            divider_prev <= 15'h0000;
        end else if (timer_unit_clock_gate) begin
            divider      <= divider + 15'h0001;
            divider_prev <= divider;
        end
    end
    logic [15:0] tick_n;
    assign tick_n = {divider_prev & ~divider, 1'b1};
    wire [3:0] prs0 = prescaler_reg[3:0];
    wire tick_first = timer_unit_clock_gate && tick_n[prs0];
    wire [3:0] prs1 = prescaler_reg[7:4];
    wire [3:0] prs2 = {2'h0, prescaler_reg[9:8]};
    wire [3:0] prs3 = {2'h0, prescaler_reg[13:12]};
    wire tick_second = timer_unit_clock_gate && tick_n[prs1];
    wire tick_third  = timer_unit_clock_gate && tick_n[prs2];
    wire tick_fourth = timer_unit_clock_gate && tick_n[prs3];

    tcpp_mode_type m0;
    tcpp_mode_type m1;
    assign m0 = tcpp_unpack(master_mode);
    assign m1 = tcpp_unpack(slave_mode);

    function automatic logic pick_tick(input logic [1:0] sel, input logic a, input logic b,
                                       input logic c, input logic d);
        case (sel)
            2'h0:    pick_tick = a;
            2'h1:    pick_tick = c;
            2'h2:    pick_tick = b;
            default: pick_tick = d;
        endcase
    endfunction : pick_tick

    // pin edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin0_prev <= 1'b0;
            pin1_prev <= 1'b0;
        end else begin
            pin0_prev <= channel_zero_input_pin;
            pin1_prev <= channel_one_input_pin;
        end
    end
    wire rise0 = channel_zero_input_pin && !pin0_prev;
    wire fall0 = !channel_zero_input_pin && pin0_prev;
    wire rise1 = channel_one_input_pin && !pin1_prev;
    wire fall1 = !channel_one_input_pin && pin1_prev;
    wire edge0 = m0.input_edge_field == 2'h0 ? fall0 : m0.input_edge_field == 2'h1 ? rise0 : (rise0 || fall0);
    wire edge1 = m1.input_edge_field == 2'h0 ? fall1 : m1.input_edge_field == 2'h1 ? rise1 : (rise1 || fall1);
    wire start_edge0 = m0.input_edge_field[1] ? (m0.input_edge_field[0] ? rise0 : fall0) : edge0;
    wire start_edge1 = m1.input_edge_field[1] ? (m1.input_edge_field[0] ? rise1 : fall1) : edge1;

    // count clock: operating clock or pin valid edge
    wire op_tick0 = pick_tick(m0.operating_clock_select, tick_first, tick_second, tick_third, tick_fourth);
    wire op_tick1 = pick_tick(m1.operating_clock_select, tick_first, tick_second, tick_third, tick_fourth);
    wire cnt_tick0 = timer_unit_clock_gate && (m0.count_clock_source ? edge0 : op_tick0);
    wire cnt_tick1 = timer_unit_clock_gate && (m1.count_clock_source ? edge1 : op_tick1);

    // start-trigger bits and operation flags
    logic [1:0] sw_start;
    assign sw_start = start_wr ? w_data[1:0] : 2'h0;
    // the write that sets a flag may start its channel in the same edge
    wire [1:0] enabled_now = channel_operation_flag | sw_start;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            channel_operation_flag <= 2'h0;
        end else begin
            channel_operation_flag <= enabled_now;
        end
    end

    // external start triggers
    function automatic logic ext_trig(input logic [2:0] sts, input logic e, input logic st, input logic mi);
        case (sts)
            STS_EDGE:   ext_trig = e;
            STS_BOTH:   ext_trig = st;
            STS_MASTER: ext_trig = mi;
            default:    ext_trig = 1'b0;
        endcase
    endfunction : ext_trig

    // channel 0: master sets group period
    wire trig0 = enabled_now[0] && (m0.trigger_source_field == STS_SOFT ? sw_start[0]
              : ext_trig(m0.trigger_source_field, edge0, start_edge0, 1'b0));
    wire down0 = m0.operating_mode_field != MD_CAPTURE && m0.operating_mode_field != MD_CAP_ONE;
    logic run0;
    logic irq0;
    wire start0 = trig0 && (!run0 || (m0.operating_mode_field == MD_ONECOUNT && m0.start_behaviour_bit));
    // start interrupt: interval/capture with bit 0, or one-count retrigger
    wire start_irq0 = m0.start_behaviour_bit && (m0.operating_mode_field == MD_INTERVAL
                   || m0.operating_mode_field == MD_CAPTURE || (run0 && m0.operating_mode_field == MD_ONECOUNT));
    wire zero0 = run0 && cnt_tick0 && down0 && count0 == 16'h0000;
    wire next_irq0 = start0 ? start_irq0 : zero0;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count0 <= DATA_RESET;
            run0   <= 1'b0;
            irq0   <= 1'b0;
        end else begin
            irq0 <= next_irq0;
            if (start0) begin
                count0 <= down0 ? master_period : DATA_RESET;
                run0   <= 1'b1;
            end else if (run0 && cnt_tick0) begin
                if (!down0) begin
                    count0 <= count0 + 16'h0001;
                end else if (count0 == 16'h0000) begin
                    // period = data + 1 count clocks
                    if (m0.operating_mode_field == MD_INTERVAL) count0 <= master_period;
                    else if (m0.operating_mode_field != MD_EVENT) run0 <= 1'b0;
                    else count0 <= master_period;
                end else begin
                    count0 <= count0 - 16'h0001;
                end
            end
        end
    end
    wire master_irq_to_group = next_irq0 && m0.split_or_master;

    // channel 1: one-count slave
    wire trig1 = enabled_now[1] && (m1.trigger_source_field == STS_SOFT ? sw_start[1]
              : ext_trig(m1.trigger_source_field, edge1, start_edge1, master_irq_to_group));
    wire down1 = m1.operating_mode_field != MD_CAPTURE && m1.operating_mode_field != MD_CAP_ONE;
    // 8-bit mode loads only the low byte of the data
    wire [15:0] load1 = m1.split_or_master ? {8'h00, slave_duty_value[7:0]} : slave_duty_value;
    logic run1;
    logic irq1;
    // one-count stops as it reaches zero, so the pin is high for data ticks
    wire last1 = count1 == 16'h0000 || (count1 == 16'h0001 && m1.operating_mode_field == MD_ONECOUNT);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count1 <= DATA_RESET;
            run1   <= 1'b0;
            irq1   <= 1'b0;
        end else begin
            irq1 <= 1'b0;
            // capture one-count and bit 0 clear ignore retriggers
            if (trig1 && (!run1 || (m1.operating_mode_field == MD_ONECOUNT && m1.start_behaviour_bit))) begin
                count1 <= down1 ? load1 : DATA_RESET;
                run1   <= 1'b1;
                irq1   <= m1.start_behaviour_bit && (m1.operating_mode_field == MD_INTERVAL
                       || m1.operating_mode_field == MD_CAPTURE || (run1 && m1.operating_mode_field == MD_ONECOUNT));
            end else if (run1 && cnt_tick1) begin
                if (!down1) begin
                    count1 <= count1 + 16'h0001;
                end else if (last1) begin
                    irq1 <= 1'b1;
                    if (m1.operating_mode_field == MD_INTERVAL || m1.operating_mode_field == MD_EVENT) count1 <= load1;
                    else run1 <= 1'b0;
                    if (m1.operating_mode_field == MD_ONECOUNT) count1 <= DATA_RESET;
                end else begin
                    count1 <= count1 - 16'h0001;
                end
            end
        end
    end

    // slave output: set by master, clear by slave; duty = duty/(period+1)
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_out <= 1'b0;
        end else if (out_ctrl[OM_BIT]) begin
            if (irq1) timer_out <= 1'b0;
            else if (irq0) timer_out <= 1'b1;
        end else if (irq1) begin
            timer_out <= !timer_out;
        end
    end
    assign pwm_output_pin          = out_ctrl[OE_BIT] ? timer_out : out_ctrl[OUTV_BIT];
    assign master_expiry_interrupt = irq0;
    assign slave_expiry_interrupt  = irq1;
endmodule : tcpp_timer

// ===== tcpp_timer_assertions.sv
// Purpose: bus and pin checks for tcpp_timer
// Assumes: write address and data offered together
// Notes:   out ctrl copy follows writes taken in one edge only
`timescale 1ns/1ps
module tcpp_timer_assertions
    import tcpp_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        pwm_output_pin,
    input wire logic        master_expiry_interrupt,
    input wire logic        slave_expiry_interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic oe;
    logic lvl;
    wire  wr_ctl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == ADDR_OUT_CTRL;
    logic       pend;
    logic [2:0] pdat;
    // the design applies a write one edge after it is taken; the copy keeps that lag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oe   <= 1'b0;
            lvl  <= 1'b0;
            pend <= 1'b0;
            pdat <= 3'h0;
        end else begin
            pend <= wr_ctl;
            pdat <= s_axi_wdata[2:0];
            if (pend) begin
                oe  <= pdat[OE_BIT];
                // level is ignored while the timer owns the pin
                lvl <= oe ? lvl : pdat[OUTV_BIT];
            end
        end
    end
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_timer_owned;
        oe && $past(oe);
    endsequence
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped early");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped early");
    a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
    a_b_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid) else $error("no write response");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
    a_reset_quiet: assert property ($fell(rst) |-> !pwm_output_pin && !master_expiry_interrupt)
        else $error("outputs active after reset");
    a_soft_level: assert property (!oe |-> pwm_output_pin == lvl)
        else $error("pin not at software level");
    a_pwm_set: assert property (s_timer_owned ##0 $rose(pwm_output_pin) |-> master_expiry_interrupt || $past(master_expiry_interrupt))
        else $error("pwm set without master expiry");
    a_pwm_clear: assert property (s_timer_owned ##0 $fell(pwm_output_pin) |-> slave_expiry_interrupt || $past(slave_expiry_interrupt))
        else $error("pwm cleared without slave expiry");
endmodule : tcpp_timer_assertions
bind tcpp_timer tcpp_timer_assertions u_chk (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .pwm_output_pin, .master_expiry_interrupt, .slave_expiry_interrupt);

// ===== tcpp_timer_tb.sv
// Purpose: self-checking bench for tcpp_timer
// Assumes: 50 MHz clk, gate and prescaler set before channels
// Notes:   pwm duty measured with prescaler zero
`timescale 1ns/1ps
module tcpp_timer_tb
    import tcpp_pkg::*;
;
    typedef struct { logic [31:0] prs; logic [31:0] mode; int gap; } tcpp_row_type;
    localparam int PER  = 9;
    localparam int DUTY = 4;
    logic        clk, rst, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr, pwm, mint;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdt, rd;
    logic [1:0]  brsp, rrsp, rsp;
    int          miscompares, samples_checked, n, hi;
    // rows: prescaler word, master mode, expected gap between master expiries
    tcpp_row_type rows [6] = '{'{32'h0, 32'h0801, PER + 1}, '{32'h1, 32'h0801, (PER + 1) * 2},
        '{32'h0201, 32'h4801, (PER + 1) * 4}, '{32'h0031, 32'h8801, (PER + 1) * 8},
        '{32'h3001, 32'hC801, (PER + 1) * 8}, '{32'h3, 32'h0801, (PER + 1) * 8}};
    tcpp_timer DUT (.clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'h3), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(brsp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdt), .s_axi_rresp(rrsp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .channel_zero_input_pin(1'b0), .channel_one_input_pin(1'b0), .pwm_output_pin(pwm),
        .master_expiry_interrupt(mint), .slave_expiry_interrupt());
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // handshakes and answers are taken at the rising edge where they are sampled
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awa <= a;
        wd  <= d;
        awv <= 1'b1;
        wv  <= 1'b1;
        br  <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_r) wv <= 1'b0;
        end while (!bv);
        rsp = brsp;
        br <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr  <= 1'b1;
        do begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
        end while (!rv);
        rd  = rdt;
        rsp = rrsp;
        rr <= 1'b0;
    endtask : rdr
    task automatic wait_int(input int lim);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (mint !== 1'b1 && n < lim);
    endtask : wait_int
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        complete_run();
    end
    initial begin
        rst = 1'b1;
        {awa, wd, awv, wv, br, ara, arv, rr} = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rdr(8'(i * 4));
            check("reset value", rd, 32'h0);
        end
        rdr(8'h40);
        check("unmapped resp", 32'(rsp), 32'(RESP_SLVERR));
        $display("test reset done");
        wr(ADDR_CLOCK_GATE, 32'h1);
        wr(ADDR_PRESCALER, 32'h0);
        wr(ADDR_MASTER_MODE, 32'h0801);
        wr(ADDR_MASTER_PER, 32'(PER));
        wr(ADDR_SLAVE_MODE, 32'h0409);
        wr(ADDR_SLAVE_DUTY, 32'(DUTY));
        wr(ADDR_OUT_CTRL, 32'h3);
        wr(ADDR_START, 32'h3);
        rdr(ADDR_STATUS);
        check("operation flags", rd & 32'h3, 32'h3);
        foreach (rows[i]) begin
            wr(ADDR_PRESCALER, rows[i].prs);
            wr(ADDR_MASTER_MODE, rows[i].mode);
            repeat (3) wait_int(500);
            check("master period", 32'(n), 32'(rows[i].gap));
        end
        $display("test period rows done");
        wr(ADDR_PRESCALER, 32'h0);
        wr(ADDR_MASTER_MODE, 32'h0801);
        repeat (2) wait_int(500);
        hi = 0;
        repeat (PER + 1) begin
            @(negedge clk);
            hi += int'(pwm === 1'b1);
        end
        check("pwm high cycles", 32'(hi), 32'(DUTY));
        $display("test duty done");
        wr(ADDR_CLOCK_GATE, 32'h0);
        wait_int(3);
        wait_int(200);
        check("gated expiry wait", 32'(n), 32'd200);
        wr(ADDR_CLOCK_GATE, 32'h1);
        repeat (2) wait_int(500);
        check("resumed period", 32'(n), 32'(PER + 1));
        $display("test clock gate done");
        wr(ADDR_OUT_CTRL, 32'h0);
        wr(ADDR_OUT_CTRL, 32'h4);
        @(negedge clk);
        check("software level", 32'(pwm), 32'h1);
        $display("test software level done");
        complete_run();
    end
endmodule : tcpp_timer_tb
